// File: common/dcal_pkg.sv
// dcal_pkg: opcodes, flag layout and constants for the add/logic/branch core
package dcal_pkg;
    localparam int DW = 16;          // data word width
    localparam int AW = 40;          // accumulator width
    localparam int RA = 4;           // register address width (16 regs)
    localparam int FA = 8;           // file address width
    localparam logic [3:0] DEFAULT_WORK_REG_IDX = 4'h0; // default_work_reg index
    localparam logic [DW-1:0] RST_WORD = 16'h0000;
    localparam logic [AW-1:0] RST_ACC = 40'h00_0000_0000;
    localparam logic [AW-1:0] ACC_MAX = 40'h00_7fff_ffff;
    localparam logic [AW-1:0] ACC_MIN = 40'hff_8000_0000;
    localparam logic [15:0] RST_PC = 16'h0000;
    localparam int TAKEN_CYC = 2;    // cycles for a taken jump
    // flag positions in the status word
    localparam int F_C = 0;
    localparam int F_Z = 1;
    localparam int F_OV = 2;
    localparam int F_N = 3;
    localparam int F_DC = 4;
    localparam int F_OA = 5;
    localparam int F_OB = 6;
    localparam int F_SA = 7;
    localparam int F_SB = 8;
    localparam logic [8:0] RST_FLAGS = 9'h000;

    // operation codes
    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_ADD_ACC = 5'h01, OP_ADD = 5'h02,
        OP_ADD_SACC = 5'h03, OP_ADD_CARRY_OP = 5'h04, OP_AND = 5'h05,
        OP_SRA1 = 5'h06, OP_SRAN = 5'h07, OP_BIT_CLEAR_OP = 5'h08,
        OP_BIT_SET_OP = 5'h09, OP_JCOND = 5'h0a, OP_JMP = 5'h0b,
        OP_JREG = 5'h0c, OP_BSW = 5'h0d
    } dcal_op_t;

    // operand forms
    typedef enum logic [2:0] {
        FM_F = 3'h0, FM_F_W = 3'h1, FM_LIT10 = 3'h2,
        FM_RR = 3'h3, FM_RLIT5 = 3'h4
    } dcal_form_t;

    // branch conditions
    typedef enum logic [4:0] {
        CC_C = 5'h00, CC_GE = 5'h01, CC_GEU = 5'h02, CC_GT = 5'h03,
        CC_GTU = 5'h04, CC_LE = 5'h05, CC_LEU = 5'h06, CC_LT = 5'h07,
        CC_LTU = 5'h08, CC_N = 5'h09, CC_NC = 5'h0a, CC_NN = 5'h0b,
        CC_NOV = 5'h0c, CC_NZ = 5'h0d, CC_OA = 5'h0e, CC_OB = 5'h0f,
        CC_OV = 5'h10, CC_SA = 5'h11, CC_SB = 5'h12, CC_Z = 5'h13
    } dcal_cond_t;

    // one decoded instruction word
    typedef struct packed {
        dcal_op_t      op;
        dcal_form_t    form;
        dcal_cond_t    cond;
        logic [FA-1:0] faddr;    // file address
        logic [RA-1:0] rb;       // base / first source register
        logic [RA-1:0] rs;       // second source register
        logic [RA-1:0] rd;       // destination register
        logic [9:0]    lit10;    // 10-bit literal, lit5/bit4/slit4 low bits
        logic          acc_sel;  // 0 = acc A, 1 = acc B
        logic          use_z;    // flag_to_bit_write: 1 copies zero flag
        logic [15:0]   disp;     // signed word displacement
    } dcal_instr_t;
endpackage

// File: src/dcal_core.sv
// dcal_core: executes add, logic, shift, bit and branch instructions
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - add accumulators in one cycle, update only acc overflow and clipped flags
// - plain add forms take one cycle, update C, DC, N, OV, Z
// - scaled signed register added into accumulator, updates acc flags
// - add_carry_op is plain add plus carry flag, same flags
// - AND uses add's forms, one cycle, changes only N and Z
// - shift right by one keeps sign, updates C, N, OV, Z
// - multi-position arithmetic shift by register or lit5, updates N, Z
// - bit_clear_op clears one bit at 4-bit position, no flags
// - bit_set_op sets one bit at 4-bit position, no flags
// - conditional jump one cycle untaken, two taken, no flags
// - jump tests carry, N, OV, Z and signed/unsigned compares
// - jump also tests each accumulator's overflow and clipped flag
// - unconditional jump always two cycles, flags unchanged
// - flag_to_bit_write copies C or Z into register bit, no flags
module dcal_core (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst,
    input  wire logic                 i_ce,
    input  wire logic                 i_valid,
    input  wire dcal_pkg::dcal_instr_t i_instr,
    output logic                      o_ready,
    output logic [15:0]               o_pc,
    output logic                      o_flush,
    output logic [8:0]                o_flags,
    output logic [15:0]               o_wreg0,
    output logic [39:0]               o_acc_a,
    output logic [39:0]               o_acc_b
);
    // ********************************************************
    // helpers
    // ********************************************************
    // 16-bit add with carry-in; returns {c, dc, ov, sum}
    function automatic logic [18:0] add16(input logic [15:0] a,
        input logic [15:0] b, input logic ci);
        logic [16:0] s;
        logic [4:0]  d;
        logic        ov;
        s  = {1'b0, a} + {1'b0, b} + {16'h0000, ci};
        d  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        ov = (a[15] == b[15]) && (s[15] != a[15]);
        return {s[16], d[4], ov, s[15:0]};
    endfunction

    // saturating accumulator add; returns {ovf, clip, value}
    function automatic logic [41:0] acc_add(input logic [39:0] a,
        input logic [39:0] b);
        logic [40:0] s;
        logic        wrap;
        s    = {a[39], a} + {b[39], b};
        wrap = (s[40] != s[39]);
        if (wrap)
            return {1'b1, 1'b1, s[40] ? dcal_pkg::ACC_MIN
                                       : dcal_pkg::ACC_MAX};
        return {s[39:31] != {9{s[31]}}, 1'b0, s[39:0]};
    endfunction

    // ********************************************************
    // state
    // ********************************************************
    logic [15:0] regs_reg [16];
    logic [15:0] file_reg [256];
    logic [8:0]  flags_reg;
    logic [39:0] acc_a_reg;
    logic [39:0] acc_b_reg;
    logic [15:0] pc_reg;
    logic        bubble_reg;   // second cycle of a taken jump
    logic [41:0] acc_nxt_a;
    logic [41:0] acc_nxt_b;
    logic [39:0] scaled;
    logic [39:0] addend;
    logic        hit_a;
    logic        hit_b;

    dcal_pkg::dcal_instr_t ins;
    logic        go;
    logic [15:0] op_a;
    logic [15:0] op_b;
    logic [18:0] sum;
    logic [15:0] res;
    logic        wr_reg;
    logic        wr_file;
    logic [3:0]  wr_idx;
    logic        taken;
    logic [15:0] target;
    logic [15:0] next_pc;
    logic        c;
    logic        z;
    logic        n;
    logic        v;

    assign ins     = i_instr;
    assign o_ready = i_ce && !bubble_reg;
    assign go      = i_ce && i_valid && !bubble_reg;
    assign next_pc = pc_reg + 16'h0001;
    assign c = flags_reg[dcal_pkg::F_C];
    assign z = flags_reg[dcal_pkg::F_Z];
    assign n = flags_reg[dcal_pkg::F_N];
    assign v = flags_reg[dcal_pkg::F_OV];

    // ********************************************************
    // operand selection and result
    // ********************************************************
    always_comb begin
        op_a = regs_reg[ins.rb];
        op_b = regs_reg[ins.rs];
        case (ins.form)
            dcal_pkg::FM_F, dcal_pkg::FM_F_W: begin
                op_a = file_reg[ins.faddr];
                op_b = regs_reg[dcal_pkg::DEFAULT_WORK_REG_IDX];
            end
            dcal_pkg::FM_LIT10: begin
                op_a = {6'h00, ins.lit10};
                op_b = regs_reg[ins.rd];
            end
            dcal_pkg::FM_RLIT5: op_b = {11'h000, ins.lit10[4:0]};
            default: ;
        endcase
    end

    // sum feeds add and add_carry_op alike
    assign sum = add16(op_a, op_b,
        (ins.op == dcal_pkg::OP_ADD_CARRY_OP) ? c : 1'b0);

    always_comb begin
        res = sum[15:0];
        case (ins.op)
            dcal_pkg::OP_AND:  res = op_a & op_b;
            dcal_pkg::OP_SRA1: res = {op_a[15], op_a[15:1]};
            dcal_pkg::OP_SRAN: res = $signed(regs_reg[ins.rb]) >>>
                ((ins.form == dcal_pkg::FM_RLIT5) ? ins.lit10[4:0]
                 : regs_reg[ins.rs][4:0]);
            dcal_pkg::OP_BIT_CLEAR_OP: res = op_a & ~(16'h0001 << ins.lit10[3:0]);
            dcal_pkg::OP_BIT_SET_OP: res = op_a | (16'h0001 << ins.lit10[3:0]);
            dcal_pkg::OP_BSW: begin
                res = regs_reg[ins.rs];
                res[regs_reg[ins.rb][3:0]] = ins.use_z ? z : c;
            end
            default: ;
        endcase
    end

    // bit ops: form FM_F targets the file, FM_F_W file into the work register, FM_LIT10 literal into rd, else register rb into rd
    // destination routing: file forms write file unless FM_F_W
    always_comb begin
        wr_reg  = 1'b0;
        wr_file = 1'b0;
        wr_idx  = ins.rd;
        case (ins.op)
            dcal_pkg::OP_ADD, dcal_pkg::OP_ADD_CARRY_OP, dcal_pkg::OP_AND,
            dcal_pkg::OP_SRA1, dcal_pkg::OP_BIT_CLEAR_OP,
            dcal_pkg::OP_BIT_SET_OP: begin
                if (ins.form == dcal_pkg::FM_F)
                    wr_file = 1'b1;
                else begin
                    wr_reg = 1'b1;
                    if (ins.form == dcal_pkg::FM_F_W)
                        wr_idx = dcal_pkg::DEFAULT_WORK_REG_IDX;
                end
            end
            dcal_pkg::OP_SRAN: wr_reg = 1'b1;
            dcal_pkg::OP_BSW: begin
                wr_reg = 1'b1;
                wr_idx = ins.rs;
            end
            default: ;
        endcase
    end

    // ********************************************************
    // branch decision
    // ********************************************************
    always_comb begin
        taken  = 1'b0;
        target = next_pc + ins.disp;
        case (ins.op)
            dcal_pkg::OP_JMP: taken = 1'b1;
            dcal_pkg::OP_JREG: begin
                taken  = 1'b1;
                target = next_pc + regs_reg[ins.rs];
            end
            dcal_pkg::OP_JCOND: begin
                case (ins.cond)
                    dcal_pkg::CC_C:   taken = c;
                    dcal_pkg::CC_NC:  taken = !c;
                    dcal_pkg::CC_N:   taken = n;
                    dcal_pkg::CC_NN:  taken = !n;
                    dcal_pkg::CC_OV:  taken = v;
                    dcal_pkg::CC_NOV: taken = !v;
                    dcal_pkg::CC_Z:   taken = z;
                    dcal_pkg::CC_NZ:  taken = !z;
                    dcal_pkg::CC_GT:  taken = !z && (n == v);
                    dcal_pkg::CC_GE:  taken = (n == v);
                    dcal_pkg::CC_LT:  taken = (n != v);
                    dcal_pkg::CC_LE:  taken = z || (n != v);
                    dcal_pkg::CC_GTU: taken = c && !z;
                    dcal_pkg::CC_GEU: taken = c;
                    dcal_pkg::CC_LTU: taken = !c;
                    dcal_pkg::CC_LEU: taken = !c || z;
                    dcal_pkg::CC_OA:  taken = flags_reg[dcal_pkg::F_OA];
                    dcal_pkg::CC_OB:  taken = flags_reg[dcal_pkg::F_OB];
                    dcal_pkg::CC_SA:  taken = flags_reg[dcal_pkg::F_SA];
                    dcal_pkg::CC_SB:  taken = flags_reg[dcal_pkg::F_SB];
                    default:          taken = 1'b0;
                endcase
            end
            default: ;
        endcase
    end

    // ********************************************************
    // program counter and flush; taken jumps spend a bubble cycle
    // ********************************************************
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pc_reg     <= dcal_pkg::RST_PC;
            bubble_reg <= 1'b0;
        end else if (i_ce) begin
            bubble_reg <= go && taken;
            if (go)
                pc_reg <= taken ? target : next_pc;
        end
    end
    assign o_flush = bubble_reg;  // prefetched word dropped

    // ********************************************************
    // register and file write-back
    // ********************************************************
    always_ff @(posedge i_clk) begin
        if (i_ce && go && wr_reg)
            regs_reg[wr_idx] <= res;
        if (i_ce && go && wr_file)
            file_reg[ins.faddr] <= res;
    end

    // ********************************************************
    // status flags; jumps, bit ops and flag write leave them alone
    // ********************************************************
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst)
            flags_reg <= dcal_pkg::RST_FLAGS;
        else if (go) begin
            case (ins.op)
                dcal_pkg::OP_ADD, dcal_pkg::OP_ADD_CARRY_OP: begin
                    flags_reg[dcal_pkg::F_C]  <= sum[18];
                    flags_reg[dcal_pkg::F_DC] <= sum[17];
                    flags_reg[dcal_pkg::F_OV] <= sum[16];
                    flags_reg[dcal_pkg::F_N]  <= res[15];
                    flags_reg[dcal_pkg::F_Z]  <= (res == 16'h0000);
                end
                dcal_pkg::OP_AND, dcal_pkg::OP_SRAN: begin
                    flags_reg[dcal_pkg::F_N]  <= res[15];
                    flags_reg[dcal_pkg::F_Z]  <= (res == 16'h0000);
                end
                dcal_pkg::OP_SRA1: begin
                    flags_reg[dcal_pkg::F_C]  <= op_a[0];
                    flags_reg[dcal_pkg::F_OV] <= 1'b0;
                    flags_reg[dcal_pkg::F_N]  <= res[15];
                    flags_reg[dcal_pkg::F_Z]  <= (res == 16'h0000);
                end
                dcal_pkg::OP_ADD_ACC, dcal_pkg::OP_ADD_SACC: begin
                    flags_reg[dcal_pkg::F_OA] <= acc_nxt_a[41];
                    flags_reg[dcal_pkg::F_SA] <= acc_nxt_a[40];
                    flags_reg[dcal_pkg::F_OB] <= acc_nxt_b[41];
                    flags_reg[dcal_pkg::F_SB] <= acc_nxt_b[40];
                end
                default: ;
            endcase
        end
    end

    // ********************************************************
    // accumulators
    // ********************************************************
    // signed word shifted by signed 4-bit amount (left if negative)
    // both arms signed so the right shift keeps the sign; 4-bit count
    // so that -8 really shifts by eight
    assign scaled = ins.lit10[3] ?
        ($signed({{24{op_a[15]}}, op_a}) <<
            ({1'b0, ~ins.lit10[2:0]} + 4'h1)) :
        ($signed({{24{op_a[15]}}, op_a}) >>> ins.lit10[2:0]);
    assign addend = (ins.op == dcal_pkg::OP_ADD_ACC) ?
        (ins.acc_sel ? acc_a_reg : acc_b_reg) : scaled;
    assign hit_a  = !ins.acc_sel;
    assign hit_b  = !hit_a;
    assign acc_nxt_a = hit_a ? acc_add(acc_a_reg, addend)
        : {flags_reg[dcal_pkg::F_OA], flags_reg[dcal_pkg::F_SA], acc_a_reg};
    assign acc_nxt_b = hit_b ? acc_add(acc_b_reg, addend)
        : {flags_reg[dcal_pkg::F_OB], flags_reg[dcal_pkg::F_SB], acc_b_reg};

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            acc_a_reg <= dcal_pkg::RST_ACC;
            acc_b_reg <= dcal_pkg::RST_ACC;
        end else if (go && (ins.op == dcal_pkg::OP_ADD_ACC ||
                            ins.op == dcal_pkg::OP_ADD_SACC)) begin
            acc_a_reg <= acc_nxt_a[39:0];
            acc_b_reg <= acc_nxt_b[39:0];
        end
    end

    assign o_pc    = pc_reg;
    assign o_flags = flags_reg;
    assign o_wreg0 = regs_reg[dcal_pkg::DEFAULT_WORK_REG_IDX];
    assign o_acc_a = acc_a_reg;
    assign o_acc_b = acc_b_reg;
endmodule

`default_nettype wire

// File: testbench/dcal_core_monitor.sv
// dcal_core_monitor: concurrent checks on the core's ports
`timescale 1ns/10ps
`default_nettype none
module dcal_core_monitor (
    input wire logic                  i_clk,
    input wire logic                  i_rst,
    input wire logic                  i_ce,
    input wire logic                  i_valid,
    input wire dcal_pkg::dcal_instr_t i_instr,
    input wire logic                  o_ready,
    input wire logic [15:0]           o_pc,
    input wire logic                  o_flush,
    input wire logic [8:0]            o_flags,
    input wire logic [15:0]           o_wreg0,
    input wire logic [39:0]           o_acc_a,
    input wire logic [39:0]           o_acc_b
);
    // ************************************************
    // helpers: accepted instruction and its fields
    // ************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic               take;
    dcal_pkg::dcal_op_t op;
    logic [15:0]        disp;
    assign take = i_ce && i_valid && o_ready;
    assign op   = i_instr.op;
    assign disp = i_instr.disp;

    // bubble is exactly one cycle and blocks issue
    property p_flush_once;
        o_flush |=> !o_flush;
    endproperty
    a_flush_once: assert property (p_flush_once)
        else $error("flush held longer than one cycle");
    property p_flush_block;
        o_flush |-> !o_ready;
    endproperty
    a_flush_block: assert property (p_flush_block)
        else $error("issue allowed during bubble");
    property p_jmp;
        take && op == dcal_pkg::OP_JMP |=> o_flush && $stable(o_flags)
            && o_pc == $past(o_pc) + 16'h1 + $past(disp);
    endproperty
    a_jmp: assert property (p_jmp)
        else $error("unconditional jump target or timing wrong");
    property p_jreg;
        take && op == dcal_pkg::OP_JREG |=> o_flush ##1 !o_flush;
    endproperty
    a_jreg: assert property (p_jreg)
        else $error("computed jump not two cycles");
    property p_jcond;
        take && op == dcal_pkg::OP_JCOND |=> $stable(o_flags) && (o_flush ?
            o_pc == $past(o_pc) + 16'h1 + $past(disp) :
            o_pc == $past(o_pc) + 16'h1);
    endproperty
    a_jcond: assert property (p_jcond)
        else $error("conditional jump pc or flags wrong");
    property p_bit_flags;
        take && (op == dcal_pkg::OP_BIT_CLEAR_OP || op == dcal_pkg::OP_BIT_SET_OP ||
            op == dcal_pkg::OP_BSW) |=> $stable(o_flags) && !o_flush;
    endproperty
    a_bit_flags: assert property (p_bit_flags)
        else $error("bit operation changed flags");
    // C, OV, DC and accumulator flags are masked in
    property p_and_flags;
        take && op == dcal_pkg::OP_AND |=>
            (o_flags & 9'h1f5) == ($past(o_flags) & 9'h1f5);
    endproperty
    a_and_flags: assert property (p_and_flags)
        else $error("logic and touched carry or overflow");
    property p_sran_flags;
        take && op == dcal_pkg::OP_SRAN |=>
            (o_flags & 9'h1f5) == ($past(o_flags) & 9'h1f5);
    endproperty
    a_sran_flags: assert property (p_sran_flags)
        else $error("multi shift touched carry or overflow");
    property p_acc_flags;
        take && (op == dcal_pkg::OP_ADD_ACC || op == dcal_pkg::OP_ADD_SACC)
            |=> o_flags[4:0] == $past(o_flags[4:0]);
    endproperty
    a_acc_flags: assert property (p_acc_flags)
        else $error("accumulator add touched word flags");
    property p_add_pc;
        take && (op == dcal_pkg::OP_ADD || op == dcal_pkg::OP_ADD_CARRY_OP) |=>
            o_pc == $past(o_pc) + 16'h1 && !o_flush
            && o_flags[8:5] == $past(o_flags[8:5]);
    endproperty
    a_add_pc: assert property (p_add_pc)
        else $error("word add not single cycle");
    c_taken: cover property (take && op == dcal_pkg::OP_JCOND ##1 o_flush);
    c_acc:   cover property (take && op == dcal_pkg::OP_ADD_ACC);
    c_sran:  cover property (take && op == dcal_pkg::OP_SRAN);
endmodule
bind dcal_core dcal_core_monitor u_mon (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_valid(i_valid),
    .i_instr(i_instr), .o_ready(o_ready), .o_pc(o_pc), .o_flush(o_flush),
    .o_flags(o_flags), .o_wreg0(o_wreg0), .o_acc_a(o_acc_a),
    .o_acc_b(o_acc_b)
);
`default_nettype wire

// File: testbench/dcal_core_tb.sv
// dcal_core_tb: directed self-checking bench for the core
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module dcal_core_tb;
    // ************************************************
    // clock, stimulus and expected state
    // ************************************************
    logic                  i_clk = 1'b0;
    logic                  i_rst = 1'b1;
    logic                  i_ce = 1'b1;
    logic                  i_valid = 1'b0;
    dcal_pkg::dcal_instr_t i_instr = '0;
    logic                  o_ready, o_flush;
    logic [15:0]           o_pc, o_wreg0, er0, epc;
    logic [8:0]            o_flags, ef;
    logic [39:0]           o_acc_a, o_acc_b;
    int                    failures = 0;
    int                    checks = 0;
    int                    cyc = 0;
    always #50 i_clk = ~i_clk;
    dcal_core uut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
        .i_valid(i_valid), .i_instr(i_instr), .o_ready(o_ready),
        .o_pc(o_pc), .o_flush(o_flush), .o_flags(o_flags),
        .o_wreg0(o_wreg0), .o_acc_a(o_acc_a), .o_acc_b(o_acc_b));
    // hang guard: whole run needs well under this
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // all operands use register 0 so results show on o_wreg0
    function automatic dcal_pkg::dcal_instr_t mk(input dcal_pkg::dcal_op_t op,
        input dcal_pkg::dcal_form_t fm, input logic [9:0] lit,
        input logic [15:0] disp);
        mk = '0;
        mk.op = op;
        mk.form = fm;
        mk.lit10 = lit;
        mk.disp = disp;
    endfunction
    // word add model: carry, digit carry, signed wrap
    task automatic eadd(input logic [15:0] a, b, input logic ci);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b} + {16'h0, ci};
        ef[0] = s[16];
        ef[1] = (s[15:0] == 16'h0);
        ef[2] = (a[15] == b[15]) && (s[15] != a[15]);
        ef[3] = s[15];
        ef[4] = ({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci}) > 5'hf;
        er0 = s[15:0];
    endtask
    function automatic logic taken(input dcal_pkg::dcal_cond_t c,
        input logic [8:0] f);
        logic lt;
        lt = f[3] ^ f[2];
        case (c)
            dcal_pkg::CC_C:   taken = f[0];
            dcal_pkg::CC_NC:  taken = !f[0];
            dcal_pkg::CC_Z:   taken = f[1];
            dcal_pkg::CC_NZ:  taken = !f[1];
            dcal_pkg::CC_OV:  taken = f[2];
            dcal_pkg::CC_NOV: taken = !f[2];
            dcal_pkg::CC_N:   taken = f[3];
            dcal_pkg::CC_NN:  taken = !f[3];
            dcal_pkg::CC_GE:  taken = !lt;
            dcal_pkg::CC_GT:  taken = !lt && !f[1];
            dcal_pkg::CC_LE:  taken = lt || f[1];
            dcal_pkg::CC_LT:  taken = lt;
            dcal_pkg::CC_GEU: taken = f[0];
            dcal_pkg::CC_GTU: taken = f[0] && !f[1];
            dcal_pkg::CC_LEU: taken = !f[0] || f[1];
            dcal_pkg::CC_LTU: taken = !f[0];
            dcal_pkg::CC_OA:  taken = f[5];
            dcal_pkg::CC_OB:  taken = f[6];
            dcal_pkg::CC_SA:  taken = f[7];
            default:          taken = f[8];
        endcase
    endfunction
    // issue one instruction, hold it until accepted, let results land
    task automatic exec(input dcal_pkg::dcal_instr_t ins);
        @(posedge i_clk);
        i_instr <= ins;
        i_valid <= 1'b1;
        do @(posedge i_clk); while (o_ready !== 1'b1);
        i_valid <= 1'b0;
        epc = epc + 16'h1;
        #1;
    endtask
    task automatic chk_st(input string nm);
        `CHK({nm, " reg"}, er0, o_wreg0)
        `CHK({nm, " flags"}, ef, o_flags)
        `CHK({nm, " pc"}, epc, o_pc)
    endtask
    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_add();
        exec(mk(dcal_pkg::OP_AND, dcal_pkg::FM_RLIT5, 10'h0, 16'h0));
        er0 = 16'h0;
        ef[3:1] = 3'b001;
        chk_st("and zero");
        exec(mk(dcal_pkg::OP_ADD, dcal_pkg::FM_LIT10, 10'h3ff, 16'h0));
        eadd(er0, 16'h03ff, 1'b0);
        chk_st("add lit10");
        exec(mk(dcal_pkg::OP_BIT_SET_OP, dcal_pkg::FM_RR, 10'hf, 16'h0));
        er0[15] = 1'b1;
        chk_st("bit set");
        exec(mk(dcal_pkg::OP_ADD, dcal_pkg::FM_RR, 10'h0, 16'h0));
        eadd(er0, er0, 1'b0);
        chk_st("add wrap");
        exec(mk(dcal_pkg::OP_ADD_CARRY_OP, dcal_pkg::FM_LIT10, 10'h1, 16'h0));
        eadd(er0, 16'h1, ef[0]);
        chk_st("add carry");
        exec(mk(dcal_pkg::OP_BIT_CLEAR_OP, dcal_pkg::FM_RR, 10'hb, 16'h0));
        er0[11] = 1'b0;
        chk_st("bit clear");
    endtask
    task automatic t_shift();
        exec(mk(dcal_pkg::OP_ADD, dcal_pkg::FM_LIT10, 10'h1, 16'h0));
        eadd(er0, 16'h1, 1'b0);
        exec(mk(dcal_pkg::OP_BIT_SET_OP, dcal_pkg::FM_RR, 10'hf, 16'h0));
        er0 = 16'h8001;
        exec(mk(dcal_pkg::OP_SRA1, dcal_pkg::FM_RR, 10'h0, 16'h0));
        er0 = 16'hc000;
        ef[3:0] = 4'b1001;
        chk_st("shift one");
        exec(mk(dcal_pkg::OP_SRAN, dcal_pkg::FM_RLIT5, 10'he, 16'h0));
        er0 = 16'hffff;
        chk_st("shift many");
    endtask
    task automatic t_bsw();
        dcal_pkg::dcal_instr_t ins;
        exec(mk(dcal_pkg::OP_AND, dcal_pkg::FM_RLIT5, 10'h0, 16'h0));
        er0 = 16'h0;
        ef[3:1] = 3'b001;
        ins = mk(dcal_pkg::OP_BSW, dcal_pkg::FM_RR, 10'h0, 16'h0);
        exec(ins);
        er0 = 16'h1;
        chk_st("carry to bit");
        ins.use_z = 1'b1;
        exec(ins);
        er0 = 16'h3;
        chk_st("zero to bit");
    endtask
    // every condition code against the current flags
    task automatic t_cond(input logic [15:0] disp);
        dcal_pkg::dcal_instr_t ins;
        logic                  tk;
        ins = mk(dcal_pkg::OP_JCOND, dcal_pkg::FM_F, 10'h0, disp);
        for (int k = 0; k < 20; k++) begin
            ins.cond = dcal_pkg::dcal_cond_t'(k[4:0]);
            tk = taken(ins.cond, ef);
            exec(ins);
            if (tk)
                epc = epc + disp;
            `CHK("jump flush", tk, o_flush)
            chk_st("jump cond");
        end
    endtask
    task automatic t_jump();
        exec(mk(dcal_pkg::OP_JMP, dcal_pkg::FM_F, 10'h0, 16'hfffd));
        epc = epc + 16'hfffd;
        `CHK("jump bubble", 1'b1, o_flush)
        chk_st("jump");
        exec(mk(dcal_pkg::OP_JREG, dcal_pkg::FM_F, 10'h0, 16'h0));
        epc = epc + er0;
        `CHK("computed bubble", 1'b1, o_flush)
        chk_st("computed");
    endtask
    task automatic t_wrap_flags();
        exec(mk(dcal_pkg::OP_AND, dcal_pkg::FM_RLIT5, 10'h0, 16'h0));
        exec(mk(dcal_pkg::OP_ADD, dcal_pkg::FM_LIT10, 10'h3ff, 16'h0));
        for (int b = 10; b < 15; b++)
            exec(mk(dcal_pkg::OP_BIT_SET_OP, dcal_pkg::FM_RR, 10'(b), 16'h0));
        exec(mk(dcal_pkg::OP_ADD, dcal_pkg::FM_LIT10, 10'h1, 16'h0));
        eadd(16'h7fff, 16'h1, 1'b0);
        chk_st("add overflow");
    endtask
    task automatic t_acc();
        dcal_pkg::dcal_instr_t ins;
        logic [39:0]           a;
        exec(mk(dcal_pkg::OP_ADD_SACC, dcal_pkg::FM_RR, 10'h0, 16'h0));
        chk_st("scaled add");
        `CHK("acc b kept", 40'h0, o_acc_b)
        a = 40'hff_ffff_8000;
        `CHK("acc a scaled", a, o_acc_a)
        ins = mk(dcal_pkg::OP_ADD_ACC, dcal_pkg::FM_F, 10'h0, 16'h0);
        ins.acc_sel = 1'b1;
        exec(ins);
        `CHK("acc sum", a, o_acc_b)
        `CHK("acc a kept", a, o_acc_a)
        chk_st("acc add");
    endtask
    // enable low must freeze issue even with a valid request
    task automatic t_ce();
        @(posedge i_clk);
        i_ce <= 1'b0;
        i_valid <= 1'b1;
        i_instr <= mk(dcal_pkg::OP_ADD, dcal_pkg::FM_LIT10, 10'h5, 16'h0);
        repeat (3) @(posedge i_clk);
        #1;
        `CHK("ready frozen", 1'b0, o_ready)
        chk_st("frozen");
        @(posedge i_clk);
        i_ce <= 1'b1;
        i_valid <= 1'b0;
    endtask
    initial begin
        epc = 16'h0;
        ef = 9'h0;
        er0 = 16'h0;
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        #1;
        `CHK("reset flags", 9'h0, o_flags)
        `CHK("reset pc", 16'h0, o_pc)
        `CHK("reset acc", 40'h0, o_acc_a)
        t_add();
        t_shift();
        t_bsw();
        t_cond(16'h0004);
        t_jump();
        t_wrap_flags();
        t_cond(16'hfff8);
        t_acc();
        t_ce();
        results();
    end
endmodule
`default_nettype wire
